// *** sram_ctrl.sv ***
// Host-side controller for a 512K x 8 asynchronous static memory.
// Assumes the memory pins are wired directly and a testbench resolves the data bus.
// Read data is sampled a full cycle after the strobes, so it arrives settled.
//
// Overview of operation
// R1: Memory holds 524,288 eight-bit words, 19-bit address, 8-bit two-way bus.
// R2: Select high puts memory in standby, bus released, other controls ignored.
// R3: Chip select serves both for access selection and retention entry.
// R4: Read/write line stays high for the whole read cycle.
// R5: Memory releases bus within 30 ns after output enable rises.
// R6: Memory releases bus within 30 ns after chip select rises.
// R7: Select falling with or after write low means memory never drives.
// R8: Select rising with or before write high keeps outputs released.
// R9: Output enable high throughout a write keeps memory outputs released.
// R10: Controller never drives data while memory may still drive.
// R11: Chip select held low at least 60 ns before write ends.
// R12: Memory releases bus within 30 ns after write line falls.
// R13: Memory may drive again 0 ns after write line returns high.
// R14: Read data valid within 35 ns after output enable falls.
// R15: Read data valid within 70 ns after chip select falls.
// R16: Previous read data held at least 10 ns after address change.
// R17: Memory starts driving no sooner than 5 ns after select falls.
// R18: Raise chip select no later than the start of supply reduction.
// R19: Select low, output enable low, write high: memory drives word.
// R20: Select low, write low: memory takes bus data and stores it.
// R21: After supply returns, wait several milliseconds before new access.
`timescale 1ns/1ps
`default_nettype none
`include "sram_ctrl_params.svh"

module sram_ctrl #(
  parameter int unsigned RECOVERY_CYCLES = `RECOVERY_CYCLES
) (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  input  wire logic                  req_valid,
  output logic                       req_ready,
  input  wire logic                  req_write,
  input  wire sram_ctrl_pkg::addr_type req_addr,
  input  wire sram_ctrl_pkg::data_type req_wdata,
  output logic                       rsp_valid,
  output sram_ctrl_pkg::data_type    rsp_rdata,
  input  wire logic                  retain_req,
  output logic                       retain_ack,
  output sram_ctrl_pkg::addr_type    word_address,
  output logic                       sel_n,
  output logic                       out_en_n,
  output logic                       write_n,
  input  wire sram_ctrl_pkg::data_type data_bus_in,
  output sram_ctrl_pkg::data_type    data_bus_out,
  output logic                       data_bus_oe
);
  import sram_ctrl_pkg::*;

  // Phase lengths in whole clock cycles
  localparam logic [3:0]  READ_CYC  = 4'(`READ_CYCLES);
  localparam logic [3:0]  WRITE_CYC = 4'(`WRITE_CYCLES);
  localparam logic [3:0]  TURN_CYC  = 4'(`TURN_CYCLES);
  localparam logic [19:0] RECOV_CYC = 20'(RECOVERY_CYCLES);

  ctrl_state_type state_ff;
  ctrl_state_type nxt_state;
  logic [3:0]     cnt_ff;
  logic [19:0]    recov_ff;
  addr_type       addr_ff;
  data_type       wdata_ff;
  data_type       rdata_ff;
  logic           rsp_ff;
  logic           last_cyc;
  logic           accept;
  logic           read_done;

  // Request taken at this edge: idle, no retention pending, request present
  function automatic logic take_request(input ctrl_state_type s,
                                        input logic           valid,
                                        input logic           retain);
    return (s == ST_IDLE) && valid && !retain;
  endfunction

  // Memory is selected in both access states and nowhere else
  function automatic logic selects_memory(input ctrl_state_type s);
    return (s == ST_READ) || (s == ST_WRITE);
  endfunction

  // Write line low and bus driven only in the write state
  function automatic logic writes_memory(input ctrl_state_type s);
    return (s == ST_WRITE);
  endfunction

  // Phase timer reaches its end
  assign last_cyc   = (cnt_ff == 4'h1);
  // Retention outranks a request presented in the same cycle
  assign req_ready  = (state_ff == ST_IDLE) && !retain_req;
  assign accept     = take_request(state_ff, req_valid, retain_req);
  // Read access ends with this edge; data is sampled then
  assign read_done  = (state_ff == ST_READ) && last_cyc;
  assign retain_ack = (state_ff == ST_RETAIN);

  // Next-state decode
  // A read always passes one turnaround cycle before the bus is reused
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (retain_req) begin
          nxt_state = ST_RETAIN; // [R3] [R18]
        end else if (req_valid) begin
          nxt_state = req_write ? ST_WRITE : ST_READ;
        end
      end
      ST_READ: begin
        if (last_cyc) begin
          nxt_state = ST_TURN;
        end
      end
      ST_WRITE: begin
        if (last_cyc) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_TURN: begin
        if (last_cyc) begin
          nxt_state = ST_IDLE; // [R10]
        end
      end
      ST_RETAIN: begin
        if (!retain_req) begin
          nxt_state = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        if (recov_ff == 20'h00001) begin
          nxt_state = ST_IDLE; // [R21]
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Phase cycle counter
  // Every least time rounds up to one whole cycle at this clock rate
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 4'h0;
    end else if (accept) begin
      cnt_ff <= req_write ? WRITE_CYC : READ_CYC; // [R11] [R15]
    end else if (read_done) begin
      cnt_ff <= TURN_CYC; // [R5] [R6]
    end else if (cnt_ff != 4'h0) begin
      cnt_ff <= cnt_ff - 4'h1;
    end
  end

  // Recovery timer after retention
  // Reloaded while retention lasts; counts down only once it ends
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      recov_ff <= 20'h00000;
    end else if (state_ff == ST_RETAIN) begin
      recov_ff <= RECOV_CYC; // [R21]
    end else if (recov_ff != 20'h00000) begin
      recov_ff <= recov_ff - 20'h00001;
    end
  end

  // Capture request address and write data
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      addr_ff  <= '0;
      wdata_ff <= '0;
    end else if (accept) begin
      addr_ff  <= req_addr; // [R1]
      wdata_ff <= req_wdata;
    end
  end

  // Sample read data at the end of the access, while still selected
  // The memory's output delay lies well inside one cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= '0;
      rsp_ff   <= 1'b0;
    end else begin
      rsp_ff <= read_done;
      if (read_done) begin
        rdata_ff <= data_bus_in; // [R14] [R15] [R19]
      end
    end
  end

  assign rsp_valid = rsp_ff;
  assign rsp_rdata = rdata_ff;

  // Pin drive; address is held stable through each access
  // Address and select change on the same edge, which the zero setup allows
  // Bus drive and select are released together at the end of a write
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sel_n        <= 1'b1;
      out_en_n     <= 1'b1;
      write_n      <= 1'b1;
      data_bus_oe  <= 1'b0;
      data_bus_out <= '0;
      word_address <= '0;
    end else begin
      word_address <= accept ? req_addr : addr_ff; // [R16]
      sel_n        <= !selects_memory(nxt_state); // [R2] [R3]
      out_en_n     <= !(nxt_state == ST_READ); // [R9]
      write_n      <= !writes_memory(nxt_state); // [R4] [R20]
      data_bus_oe  <= writes_memory(nxt_state); // [R7] [R10]
      data_bus_out <= accept ? req_wdata : wdata_ff; // [R20]
    end
  end

endmodule
`default_nettype wire

// *** sram_ctrl_params.svh ***
// Timing constants and field widths for the static memory controller.
// Assumes a 10 MHz system clock; included by the controller and its package users.
`ifndef SRAM_CTRL_PARAMS_SVH
`define SRAM_CTRL_PARAMS_SVH

`define ADDR_WIDTH        19
`define DATA_WIDTH        8
`define CLK_PERIOD_NS     100
// Printed times in ns
`define T_READ_CYCLE_NS   70
`define T_WRITE_PULSE_NS  50
`define T_SEL_TO_END_NS   60
`define T_RELEASE_NS      30
`define T_DATA_SETUP_NS   30
// Least times round up to whole cycles, at least one
`define CYC_MIN(ns)       ((((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
                           (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define READ_CYCLES       `CYC_MIN(`T_READ_CYCLE_NS)
`define WRITE_CYCLES      `CYC_MIN(`T_SEL_TO_END_NS)
`define TURN_CYCLES       `CYC_MIN(`T_RELEASE_NS)
// Supply recovery after retention, in ms
`define T_RECOVERY_MS     5
`define RECOVERY_CYCLES   (`T_RECOVERY_MS * 1000000 / `CLK_PERIOD_NS)

`endif

// *** sram_ctrl_pkg.sv ***
// Types shared by the static memory controller.
// Assumes the params header is on the include path.
`include "sram_ctrl_params.svh"
package sram_ctrl_pkg;
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_READ    = 3'b001,
    ST_WRITE   = 3'b010,
    ST_TURN    = 3'b011,
    ST_RETAIN  = 3'b100,
    ST_RECOVER = 3'b101
  } ctrl_state_type;
  typedef logic [`ADDR_WIDTH-1:0] addr_type;
  typedef logic [`DATA_WIDTH-1:0] data_type;
endpackage

// *** sram_ctrl_assertions.sv ***
// Pin sequencing checks for the memory controller.
// Bound into sram_ctrl; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module sram_ctrl_assertions (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic req_write,
  input wire logic rsp_valid,
  input wire logic retain_ack,
  input wire logic sel_n,
  input wire logic out_en_n,
  input wire logic write_n,
  input wire logic data_bus_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Accepted read and write requests
  sequence s_rd; req_valid && req_ready && !req_write; endsequence
  sequence s_wr; req_valid && req_ready && req_write; endsequence
  a_read_strobe: assert property (s_rd |=> !sel_n && !out_en_n && write_n)
    else $error("read strobes");
  a_read_answer: assert property (s_rd |-> ##[2:3] rsp_valid)
    else $error("no read answer");
  a_read_single: assert property ($fell(sel_n) && write_n |=> sel_n && out_en_n && !req_ready)
    else $error("read not ended");
  a_write_pins: assert property (s_wr |=> !sel_n && !write_n && data_bus_oe ##1 sel_n && !data_bus_oe)
    else $error("write strobes");
  a_oe_in_write: assert property (data_bus_oe |-> !sel_n && !write_n && out_en_n)
    else $error("drive outside write");
  a_read_no_drive: assert property (!out_en_n |-> write_n && !data_bus_oe)
    else $error("drive in read");
  a_retain_sel: assert property (retain_ack |-> sel_n && !req_ready)
    else $error("select in retention");
  a_busy_refuse: assert property (!sel_n |-> !req_ready)
    else $error("ready while busy");
endmodule
bind sram_ctrl sram_ctrl_assertions u_sram_ctrl_assertions (.clk_sys(clk_sys), .rst_n(rst_n),
  .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write), .rsp_valid(rsp_valid),
  .retain_ack(retain_ack), .sel_n(sel_n), .out_en_n(out_en_n), .write_n(write_n), .data_bus_oe(data_bus_oe));
`default_nettype wire

// *** sram_model.sv ***
// Behavioural 512K x 8 static memory.
// Resolves the shared data bus from both parties' enables.
`timescale 1ns/1ps
`default_nettype none
module sram_model #(
  parameter int T_ACC = 35
) (
  input  wire sram_ctrl_pkg::addr_type word_address,
  input  wire logic                    sel_n,
  input  wire logic                    out_en_n,
  input  wire logic                    write_n,
  input  wire sram_ctrl_pkg::data_type data_bus_out,
  input  wire logic                    data_bus_oe,
  output sram_ctrl_pkg::data_type      data_bus_in
);
  import sram_ctrl_pkg::*;
  data_type mem [addr_type];
  data_type rel = 8'h3c;
  logic     rd_late = 1'b0;
  wire      rd = !sel_n && !out_en_n && write_n;
  // Store while selected with write strobe low
  always @(sel_n, write_n, data_bus_oe, word_address, data_bus_out)
    if (!sel_n && !write_n && data_bus_oe) mem[word_address] = data_bus_out;
  // Late drive, prompt release
  always @(rd) if (!rd) rd_late = 1'b0; else rd_late <= #T_ACC 1'b1;
  // Released bus shows a changing pattern
  always @(rd, data_bus_oe) rel = ~rel;
  always @(data_bus_oe, data_bus_out, rd_late, word_address, rel) begin
    if (data_bus_oe) data_bus_in = data_bus_out;
    else if (rd_late && mem.exists(word_address)) data_bus_in = mem[word_address];
    else data_bus_in = rel;
  end
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Random and corner traffic through the controller into the memory model.
// Assumes package, controller, model and checker compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sram_ctrl_pkg::*;
  logic clk_sys, rst_n, req_valid, req_write, retain_req;
  logic req_ready, rsp_valid, retain_ack, sel_n, out_en_n, write_n, data_bus_oe;
  addr_type req_addr, word_address;
  data_type req_wdata, rsp_rdata, data_bus_out, data_bus_in;
  data_type exp_mem [addr_type];
  localparam int RECOV = 20; // Short recovery for simulation
  int errors = 0, n_checks = 0, cyc = 0, k;
  logic [19:0] rnd = 20'h139f4; // Seed 80372
  sram_ctrl #(.RECOVERY_CYCLES(RECOV)) u_sram_ctrl (.clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .retain_req(retain_req), .retain_ack(retain_ack),
    .word_address(word_address), .sel_n(sel_n), .out_en_n(out_en_n), .write_n(write_n),
    .data_bus_in(data_bus_in), .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe));
  sram_model u_sram_model (.word_address(word_address), .sel_n(sel_n), .out_en_n(out_en_n),
    .write_n(write_n), .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe), .data_bus_in(data_bus_in));
  initial begin
    clk_sys = 0;
    forever #50 clk_sys = ~clk_sys;
  end
  function automatic logic [19:0] lfsr(input logic [19:0] s);
    return {s[18:0], s[19] ^ s[16]};
  endfunction
  task automatic give_verdict;
    $display("errors=%0d checks=%0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic ok, input string what);
    n_checks++;
    if (ok !== 1'b1) begin
      errors++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask
  // One request at a falling edge; reads wait for the answer
  task automatic access(input logic wr, input addr_type a, input data_type d);
    req_valid = 1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    while (req_ready !== 1'b1) @(negedge clk_sys);
    @(negedge clk_sys);
    if (wr) exp_mem[a] = d;
    else begin
      req_valid = 0;
      for (k = 0; k < 4 && rsp_valid !== 1'b1; k++) @(negedge clk_sys);
      check(rsp_valid === 1'b1 && rsp_rdata === exp_mem[a], "read data");
    end
  endtask
  // Hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      give_verdict();
    end
  end
  initial begin
    {rst_n, req_valid, req_write, retain_req} = 4'h0;
    req_addr = '0;
    req_wdata = '0;
    repeat (3) @(negedge clk_sys);
    rst_n = 1;
    check(sel_n === 1'b1 && data_bus_oe === 1'b0, "idle pins");
    access(1, 19'h7ffff, 8'h5a);
    for (int i = 0; i < 16; i++) access(1, 19'(i), 8'(i * 37));
    for (int i = 0; i < 60; i++) begin
      rnd = lfsr(rnd);
      access(rnd[19], 19'(rnd[3:0]), rnd[11:4]);
    end
    req_valid = 0;
    retain_req = 1;
    repeat (2) @(negedge clk_sys);
    check(retain_ack === 1'b1 && sel_n === 1'b1, "retention");
    retain_req = 0;
    repeat (RECOV) @(negedge clk_sys);
    check(req_ready === 1'b0, "early access");
    @(negedge clk_sys);
    check(req_ready === 1'b1, "recovery end");
    access(0, 19'h7ffff, 8'h00);
    access(0, '0, 8'h00);
    give_verdict();
  end
endmodule
`default_nettype wire
